// File: hpm_pkg.sv
package hpm_pkg;

  // --------
  // Timing.
  // --------
  localparam int CLK_MHZ = 250;
  localparam real BOOT_TIME_MS = 1.5;
  localparam real WAKE_TIME_MS = 0.75;
  localparam int BOOT_CYCLES = int'(BOOT_TIME_MS * 1000.0 * CLK_MHZ);
  localparam int WAKE_CYCLES = int'(WAKE_TIME_MS * 1000.0 * CLK_MHZ);
  localparam int PWM_TIMEOUT_CYCLES = 65535;
  localparam int SNIPPET_SLOTS = 100;

  // --------
  // Register offsets.
  // --------
  localparam logic [7:0] ADDR_FAULT = 8'h00;
  localparam logic [7:0] ADDR_WARN = 8'h01;
  localparam logic [7:0] ADDR_DIAG = 8'h02;
  localparam logic [7:0] ADDR_MASK1 = 8'h03;
  localparam logic [7:0] ADDR_MASK2 = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h11;
  localparam logic [7:0] ADDR_AMP = 8'h12;
  localparam logic [7:0] ADDR_THR = 8'h13;
  localparam logic [7:0] ADDR_SEQ = 8'h14;
  localparam logic [7:0] ADDR_TRIG = 8'h15;
  localparam logic [7:0] ADDR_PIN0 = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1F;

  // --------
  // Field positions.
  // --------
  localparam int F_OC = 0;
  localparam int F_ACT = 1;
  localparam int F_SEQ = 2;
  localparam int F_OT = 3;
  localparam int F_UV = 4;
  localparam int F_DONE = 5;
  localparam int F_REP = 6;
  localparam int F_SAT = 7;
  localparam int C_STANDBY = 0;
  localparam int C_OVERDRIVE = 1;
  localparam int C_LOCK = 2;
  localparam int T_TRIGGER = 0;
  localparam int T_REPEAT = 1;
  localparam int P_MULTI = 4;

  // --------
  // Reset values and codes.
  // --------
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] THR_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PWM_MID = 8'h80;
  localparam logic [2:0] MODE_INACTIVE = 3'h0;
  localparam logic [2:0] MODE_DIRECT = 3'h1;
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam logic [2:0] MODE_REG_TRIG = 3'h3;
  localparam logic [2:0] MODE_EDGE_TRIG = 3'h4;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_STANDBY = 3'b010,
    ST_WAKE = 3'b011,
    ST_DRIVE = 3'b100
  } hpm_state_t;

endpackage

// File: hpm_pwm_meter.sv
`timescale 1ns/1ps
`default_nettype none
module hpm_pwm_meter #(
  parameter int CW = 20,
  parameter int TIMEOUT = 65535
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_pin,
  output logic [7:0] o_duty,
  output logic o_timeout
);
  import hpm_pkg::*;

  logic s1_r, s2_r, s3_r;
  logic [CW-1:0] per_r, hi_r, div_p_r;
  logic [CW:0] rem_r;
  logic [7:0] quo_r;
  logic [3:0] step_r;
  logic rise;

  // --------
  // Pin synchroniser and edge detect.
  // --------
  assign rise = s2_r & ~s3_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Period and high-time counters restart on each rising edge; the
  // period counter saturates at the timeout so a dead pin is flagged.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      per_r <= '0;
      hi_r <= '0;
      o_timeout <= 1'b0;
    end else begin
      o_timeout <= (per_r == CW'(TIMEOUT - 1));
      if (rise) begin
        per_r <= CW'(1);
        hi_r <= CW'(1);
      end else if (per_r != CW'(TIMEOUT)) begin
        per_r <= per_r + CW'(1);
        hi_r <= hi_r + CW'({1'b0, s2_r});
      end
    end
  end

  // Restoring divider: duty = high * 256 / period, eight steps. A
  // serial divider trades eight cycles of latency for a tiny area.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rem_r <= '0;
      div_p_r <= '0;
      quo_r <= 8'h00;
      step_r <= 4'h0;
      o_duty <= 8'h00;
    end else if (rise && per_r != CW'(TIMEOUT)) begin
      rem_r <= {1'b0, hi_r};
      div_p_r <= per_r;
      quo_r <= 8'h00;
      step_r <= 4'h8;
    end else if (step_r != 4'h0) begin
      if ({rem_r[CW-1:0], 1'b0} >= {1'b0, div_p_r}) begin
        rem_r <= {rem_r[CW-1:0], 1'b0} - {1'b0, div_p_r};
        quo_r <= {quo_r[6:0], 1'b1};
      end else begin
        rem_r <= {rem_r[CW-1:0], 1'b0};
        quo_r <= {quo_r[6:0], 1'b0};
      end
      step_r <= step_r - 4'h1;
    end else if (per_r == CW'(TIMEOUT)) begin
      o_duty <= s2_r ? 8'hFF : 8'h00;
    end else if (rem_r >= {1'b0, div_p_r}) begin
      o_duty <= 8'hFF;
    end else begin
      o_duty <= quo_r;
    end
  end

endmodule
`default_nettype wire

// File: hpm_playback.sv
//
// Functional notes
// - Mode 0 is inactive; standby select picks IDLE or STANDBY rest.
// - Direct mode: preset amplitude, write mode 1, drive after 0.75 ms.
// - Each amplitude write sets drive; zero disables stage, stays DRIVE.
// - Mode 0 in direct or PWM drive returns to the rest state.
// - Mode 2 derives amplitude from measured PWM duty, tracking updates.
// - Duty within the zero threshold of zero point gives zero drive.
// - Zero point is 50 % with overdrive, else 0 % plus threshold.
// - Mode 3 plays only after a host trigger write of 1.
// - Repeat request of 1 during memory DRIVE replays the sequence.
// - Sequence end sets complete flag, pulls interrupt, returns to rest.
// - Mode or trigger written 0 aborts memory playback to rest.
// - Mode 4 starts on a qualifying pin edge or trigger write.
// - Each pin holds sequence index, multiplicity and edge select.
// - Slots 0 to 99 hold waves; lock bit 0 blocks memory access.
// - Faults force IDLE until cleared; warnings leave state alone.
// - Any event pulls the open-drain interrupt line low.
// - Fault byte holds faults and notices; warning and input details apart.
// - Sequence fault from missing index, corrupt memory or PWM timeout.
// - Every flag clears on writing 1; two mask bytes gate them.
// - Warnings for supply limits, format mismatch; notices as listed.
// - 1.5 ms boot before inactive; no mode or memory service then.
`timescale 1ns/1ps
`default_nettype none
module hpm_playback #(
  parameter int BOOT_CNT = hpm_pkg::BOOT_CYCLES,
  parameter int WAKE_CNT = hpm_pkg::WAKE_CYCLES,
  parameter int PWM_TO = hpm_pkg::PWM_TIMEOUT_CYCLES,
  parameter int PINS = 3
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [PINS-1:0] i_trigger_pin,
  input wire logic i_pwm_input_pin,
  input wire logic i_overcurrent,
  input wire logic i_actuator_fault,
  input wire logic i_overtemp,
  input wire logic i_undervoltage,
  input wire logic i_sense_saturated,
  input wire logic i_drive_limited,
  input wire logic i_overdrive_limited,
  input wire logic i_format_mismatch,
  input wire logic i_missing_sequence,
  input wire logic i_memory_corrupt,
  input wire logic i_sequence_end,
  output hpm_pkg::hpm_state_t o_state,
  output logic o_stage_en,
  output logic [7:0] o_amplitude,
  output logic o_play_start,
  output logic o_play_repeat,
  output logic o_play_abort,
  output logic [3:0] o_play_index,
  output logic [3:0] o_play_loops,
  output logic o_play_multi,
  output logic o_mem_access_ok,
  output logic o_event_line_low_o,
  output logic o_event_line_low_oe
);
  import hpm_pkg::*;

  // ---------------------------------------------------------------
  // Register bank.
  // ---------------------------------------------------------------
  logic [7:0] fault_r, warn_r, diag_r, mask1_r, mask2_r;
  logic [2:0] mode_r;
  logic [7:0] ctrl_r, amp_r, thr_r, seq_r;
  logic trig_r;
  logic [6:0] pin_cfg_r [PINS];
  hpm_state_t state_r;
  logic [19:0] cnt_r;
  logic [7:0] duty;
  logic pwm_timeout;

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = i_wr && (i_addr == a);
  endfunction

  logic mem_mode, stream_mode, fault_any, trig_w1, trig_w0, mode_w0;
  logic repeat_w1, host_start, pin_start, abort, in_play, done_flag;
  logic [PINS-1:0] pin_fire;
  hpm_state_t rest_st;

  assign mem_mode = (mode_r == MODE_REG_TRIG) ||
                    (mode_r == MODE_EDGE_TRIG);
  assign stream_mode = (mode_r == MODE_DIRECT) || (mode_r == MODE_PWM);
  assign fault_any = |fault_r[F_UV:F_OC];
  assign rest_st = ctrl_r[C_STANDBY] ? ST_STANDBY : ST_IDLE;
  assign trig_w1 = wr_at(ADDR_TRIG) & i_wdata[T_TRIGGER];
  assign trig_w0 = wr_at(ADDR_TRIG) & ~i_wdata[T_TRIGGER];
  assign repeat_w1 = wr_at(ADDR_TRIG) & i_wdata[T_REPEAT];
  assign mode_w0 = wr_at(ADDR_MODE) & (i_wdata[2:0] == MODE_INACTIVE);
  assign in_play = (state_r == ST_WAKE) || (state_r == ST_DRIVE);
  assign host_start = mem_mode & trig_w1;
  assign pin_start = (mode_r == MODE_EDGE_TRIG) & (|pin_fire);
  assign abort = in_play & mem_mode & (mode_w0 | trig_w0);
  assign done_flag = (state_r == ST_DRIVE) & mem_mode & i_sequence_end;

  // ---------------------------------------------------------------
  // Trigger pins: two-stage synchroniser, then edge qualify.
  // ---------------------------------------------------------------
  logic [PINS-1:0] ps1_r, ps2_r, ps3_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ps1_r <= '0;
      ps2_r <= '0;
      ps3_r <= '0;
    end else begin
      ps1_r <= i_trigger_pin;
      ps2_r <= ps1_r;
      ps3_r <= ps2_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      logic up, dn;
      logic [1:0] es;
      assign up = ps2_r[g] & ~ps3_r[g];
      assign dn = ~ps2_r[g] & ps3_r[g];
      assign es = pin_cfg_r[g][6:5];
      // Edge select per pin: rising, falling or both.
      assign pin_fire[g] = (up & (es == EDGE_RISE || es == EDGE_BOTH)) |
                           (dn & (es == EDGE_FALL || es == EDGE_BOTH));
    end
  endgenerate

  // Lowest-numbered firing pin wins when several fire together.
  logic [1:0] pin_sel;
  always_comb begin
    pin_sel = 2'd0;
    for (int i = PINS - 1; i >= 0; i--) begin
      if (pin_fire[i]) begin
        pin_sel = 2'(i);
      end
    end
  end

  // ---------------------------------------------------------------
  // PWM duty measurement.
  // ---------------------------------------------------------------
  hpm_pwm_meter #(
    .CW(20),
    .TIMEOUT(PWM_TO)
  ) u_meter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pin(i_pwm_input_pin),
    .o_duty(duty),
    .o_timeout(pwm_timeout)
  );

  // Duty to amplitude. With overdrive the drive is signed around mid
  // scale, so flipping the top bit gives duty - 128 in two's complement.
  logic [7:0] pwm_amp, mag, amp_sel;
  always_comb begin
    mag = duty[7] ? (duty - PWM_MID) : (PWM_MID - duty);
    if (ctrl_r[C_OVERDRIVE]) begin
      pwm_amp = (mag <= thr_r) ? 8'h00 : (duty ^ PWM_MID);
    end else begin
      pwm_amp = (duty <= thr_r) ? 8'h00 : duty;
    end
    case (mode_r)
      MODE_DIRECT: amp_sel = amp_r;
      MODE_PWM: amp_sel = pwm_amp;
      default: amp_sel = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Playback state machine.
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_r <= ST_BOOT;
      cnt_r <= 20'(BOOT_CNT - 1);
    end else begin
      case (state_r)
        ST_BOOT: begin
          if (cnt_r == 20'h0_0000) begin
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 20'h0_0001;
          end
        end
        ST_IDLE, ST_STANDBY: begin
          cnt_r <= 20'(WAKE_CNT - 1);
          if (fault_any) begin
            state_r <= ST_IDLE;
          end else if (stream_mode || host_start || pin_start) begin
            state_r <= ST_WAKE;
          end else begin
            state_r <= rest_st;
          end
        end
        ST_WAKE: begin
          if (fault_any) begin
            state_r <= ST_IDLE;
          end else if (abort || mode_r == MODE_INACTIVE) begin
            state_r <= rest_st;
          end else if (cnt_r == 20'h0_0000) begin
            state_r <= ST_DRIVE;
          end else begin
            cnt_r <= cnt_r - 20'h0_0001;
          end
        end
        ST_DRIVE: begin
          if (fault_any) begin
            state_r <= ST_IDLE;
          end else if (abort || done_flag) begin
            state_r <= rest_st;
          end else if (mode_w0 || !(stream_mode || mem_mode)) begin
            state_r <= rest_st;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Playback requests toward the wave engine, one-cycle pulses.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_play_start <= 1'b0;
      o_play_repeat <= 1'b0;
      o_play_abort <= 1'b0;
      o_play_index <= 4'h0;
      o_play_loops <= 4'h0;
      o_play_multi <= 1'b0;
    end else begin
      o_play_start <= (state_r == ST_WAKE) && mem_mode && !abort &&
                      !fault_any && cnt_r == 20'h0_0000;
      o_play_repeat <= (state_r == ST_DRIVE) && mem_mode && repeat_w1 &&
                       !abort;
      o_play_abort <= abort || (in_play && mem_mode && fault_any);
      if ((state_r == ST_IDLE || state_r == ST_STANDBY) && !fault_any) begin
        if (host_start) begin
          o_play_index <= seq_r[3:0];
          o_play_loops <= seq_r[7:4];
          o_play_multi <= 1'b0;
        end else if (pin_start) begin
          o_play_index <= pin_cfg_r[pin_sel][3:0];
          o_play_loops <= seq_r[7:4];
          o_play_multi <= pin_cfg_r[pin_sel][P_MULTI];
        end
      end
    end
  end

  // Drive level follows amplitude writes and duty changes in DRIVE.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_amplitude <= 8'h00;
      o_stage_en <= 1'b0;
    end else if (state_r == ST_DRIVE && !fault_any) begin
      o_amplitude <= amp_sel;
      o_stage_en <= mem_mode || (amp_sel != 8'h00);
    end else begin
      o_amplitude <= 8'h00;
      o_stage_en <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Software-written controls.
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mode_r <= MODE_INACTIVE;
      ctrl_r <= CTRL_RESET;
      amp_r <= 8'h00;
      thr_r <= THR_RESET;
      seq_r <= 8'h00;
      mask1_r <= MASK_RESET;
      mask2_r <= MASK_RESET;
    end else if (state_r != ST_BOOT) begin
      if (wr_at(ADDR_MODE)) mode_r <= i_wdata[2:0];
      if (wr_at(ADDR_CTRL)) ctrl_r <= i_wdata;
      if (wr_at(ADDR_AMP)) amp_r <= i_wdata;
      if (wr_at(ADDR_THR)) thr_r <= i_wdata;
      if (wr_at(ADDR_SEQ)) seq_r <= i_wdata;
      if (wr_at(ADDR_MASK1)) mask1_r <= i_wdata;
      if (wr_at(ADDR_MASK2)) mask2_r <= i_wdata;
    end
  end

  // Trigger bit reads back until the sequence ends, a fault is set or the bit is written 0.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      trig_r <= 1'b0;
    end else if (wr_at(ADDR_TRIG) && state_r != ST_BOOT) begin
      trig_r <= i_wdata[T_TRIGGER];
    end else if (done_flag || fault_any) begin
      trig_r <= 1'b0;
    end
  end

  generate
    for (g = 0; g < PINS; g++) begin : g_cfg
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          pin_cfg_r[g] <= 7'h00;
        end else if (wr_at(ADDR_PIN0 + 8'(g)) && state_r != ST_BOOT) begin
          pin_cfg_r[g] <= i_wdata[6:0];
        end
      end
    end
  endgenerate

  // Memory gate: no access while booting or when the lock bit is 0.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_mem_access_ok <= 1'b0;
    end else begin
      o_mem_access_ok <= ctrl_r[C_LOCK] && state_r != ST_BOOT;
    end
  end

  // ---------------------------------------------------------------
  // Event flags: set wins over a same-cycle write-1 clear.
  // ---------------------------------------------------------------
  logic [7:0] fault_set, warn_set, diag_set;
  logic pwm_dead;
  assign pwm_dead = pwm_timeout && mode_r == MODE_PWM && in_play;
  assign diag_set = {5'h00, pwm_dead, i_memory_corrupt,
                     i_missing_sequence};
  assign warn_set = {5'h00, i_format_mismatch, i_overdrive_limited,
                     i_drive_limited};
  assign fault_set = {i_sense_saturated, o_play_repeat, done_flag,
                      i_undervoltage, i_overtemp, |diag_set,
                      i_actuator_fault, i_overcurrent};

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fault_r <= 8'h00;
      warn_r <= 8'h00;
      diag_r <= 8'h00;
    end else begin
      fault_r <= (fault_r & ~(wr_at(ADDR_FAULT) ? i_wdata : 8'h00)) |
                 fault_set;
      warn_r <= (warn_r & ~(wr_at(ADDR_WARN) ? i_wdata : 8'h00)) |
                warn_set;
      diag_r <= (diag_r & ~(wr_at(ADDR_DIAG) ? i_wdata : 8'h00)) |
                diag_set;
    end
  end

  // Open-drain line: low while any unmasked flag stays set. A pending
  // warning shows as its own notice through the second mask byte.
  logic irq_any;
  assign irq_any = |(fault_r & ~mask1_r) |
                   |(warn_r[2:0] & ~mask2_r[2:0]) |
                   (|warn_r[2:0] & ~mask2_r[3]) |
                   |(diag_r[2:0] & ~mask2_r[6:4]);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_event_line_low_o <= 1'b0;
      o_event_line_low_oe <= 1'b0;
    end else begin
      o_event_line_low_o <= 1'b0;
      o_event_line_low_oe <= irq_any;
    end
  end

  // ---------------------------------------------------------------
  // Read port: data stands only in the cycle after the strobe.
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      case (i_addr)
        ADDR_FAULT: o_rdata <= fault_r;
        ADDR_WARN: o_rdata <= warn_r;
        ADDR_DIAG: o_rdata <= diag_r;
        ADDR_MASK1: o_rdata <= mask1_r;
        ADDR_MASK2: o_rdata <= mask2_r;
        ADDR_MODE: o_rdata <= {5'h00, mode_r};
        ADDR_CTRL: o_rdata <= ctrl_r;
        ADDR_AMP: o_rdata <= amp_r;
        ADDR_THR: o_rdata <= thr_r;
        ADDR_SEQ: o_rdata <= seq_r;
        ADDR_TRIG: o_rdata <= {7'h00, trig_r};
        ADDR_STATUS: o_rdata <= {duty[7:3], state_r};
        default: begin
          o_rdata <= 8'h00;
          for (int i = 0; i < PINS; i++) begin
            if (i_addr == ADDR_PIN0 + 8'(i)) begin
              o_rdata <= {1'b0, pin_cfg_r[i]};
            end
          end
        end
      endcase
    end
  end

  assign o_state = state_r;

endmodule
`default_nettype wire

// File: hpm_playback_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module hpm_playback_monitor import hpm_pkg::*; #(
  parameter int WAKE_CNT = 10
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_sequence_end,
  input wire hpm_pkg::hpm_state_t o_state,
  input wire logic [7:0] o_amplitude,
  input wire logic o_play_start,
  input wire logic o_play_repeat,
  input wire logic o_play_abort,
  input wire logic o_mem_access_ok,
  input wire logic o_event_line_low_o
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // --------
  // Helper logic.
  // --------
  int wake_cnt_r;
  logic mem_r;
  // Counts WAKE cycles for the wake length check.
  always_ff @(posedge i_clk) begin
    if (i_srst || o_state != ST_WAKE) wake_cnt_r <= 0;
    else wake_cnt_r <= wake_cnt_r + 1;
  end
  // Mode is not visible here; a start pulse marks memory playback.
  always_ff @(posedge i_clk) begin
    if (i_srst || o_state != ST_DRIVE) mem_r <= 1'b0;
    else if (o_play_start) mem_r <= 1'b1;
  end
  sequence s_wake_done;
    o_state == ST_WAKE ##1 o_state == ST_DRIVE;
  endsequence
  // --------
  // Checks.
  // --------
  a_line_only_low: assert property (!o_event_line_low_o)
    else $error("event line driven high");
  a_boot_no_mem: assert property (o_state == ST_BOOT |-> !o_mem_access_ok)
    else $error("memory access open during boot");
  a_amp_idle_zero: assert property (o_state != ST_DRIVE &&
    $past(o_state) != ST_DRIVE |-> o_amplitude == 8'h00)
    else $error("amplitude outside drive");
  a_start_in_drive: assert property (o_play_start |-> o_state == ST_DRIVE)
    else $error("start pulse outside drive");
  a_start_one_cycle: assert property (o_play_start |=> !o_play_start)
    else $error("start pulse too long");
  a_wake_length: assert property (s_wake_done |-> wake_cnt_r == WAKE_CNT)
    else $error("wake length wrong");
  a_done_to_rest: assert property (i_sequence_end && mem_r |=>
    o_state inside {ST_IDLE, ST_STANDBY})
    else $error("no rest after sequence end");
  a_repeat_pulse: assert property (i_wr && i_addr == ADDR_TRIG &&
    i_wdata[1:0] == 2'b11 && mem_r |=> o_play_repeat)
    else $error("repeat pulse missing");
  a_trig_abort: assert property (i_wr && i_addr == ADDR_TRIG &&
    i_wdata[1:0] == 2'b00 && mem_r |=> o_play_abort)
    else $error("abort pulse missing");
  a_mode_stop: assert property (i_wr && i_addr == ADDR_MODE &&
    i_wdata[2:0] == MODE_INACTIVE && o_state == ST_DRIVE |=>
    o_state inside {ST_IDLE, ST_STANDBY})
    else $error("mode zero did not stop drive");
endmodule
bind hpm_playback hpm_playback_monitor #(.WAKE_CNT(WAKE_CNT))
  hpm_playback_monitor_inst (.*);
`default_nettype wire

// File: hpm_pwm_host.sv
`timescale 1ns/1ps
`default_nettype none
module hpm_pwm_host (
  input wire logic i_lclk,
  input wire logic i_en,
  input wire logic [2:0] i_high,
  output logic o_pwm = 1'b0
);
  logic [2:0] ph_r = 3'h0;
  // One period is eight link clocks; a stopped source rests low.
  always_ff @(posedge i_lclk) begin
    ph_r <= ph_r + 3'h1;
    o_pwm <= i_en && (ph_r < i_high);
  end
endmodule
`default_nettype wire

// File: tb_hpm_playback.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hpm_playback;
  import hpm_pkg::*;
  logic i_clk = 0, i_srst = 1, i_wr = 0, i_rd = 0, lclk = 0, pwm_en = 0;
  logic [7:0] i_addr = 0, i_wdata = 0, o_rdata, amp;
  logic [2:0] pins = 0, pwm_high = 3'h2;
  logic [9:0] ev = 0;
  logic seq_end = 0, pwm, stage, mem_ok, irq_o, irq_oe;
  logic [3:0] idx, loops;
  hpm_state_t st;
  int fail_count = 0, comparisons = 0;
  // Pull-up on the shared event line.
  wire irq_n = irq_oe ? irq_o : 1'b1;
  always #2 i_clk = ~i_clk;
  initial #1.3 forever #16 lclk = ~lclk;
  hpm_pwm_host hpm_pwm_host_inst (.i_lclk(lclk), .i_en(pwm_en),
    .i_high(pwm_high), .o_pwm(pwm));
  hpm_playback #(.BOOT_CNT(20), .WAKE_CNT(10), .PWM_TO(200))
    hpm_playback_inst (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_trigger_pin(pins), .i_pwm_input_pin(pwm), .i_overcurrent(ev[0]),
    .i_actuator_fault(ev[1]), .i_overtemp(ev[2]), .i_undervoltage(ev[3]),
    .i_sense_saturated(ev[4]), .i_drive_limited(ev[5]),
    .i_overdrive_limited(ev[6]), .i_format_mismatch(ev[7]),
    .i_missing_sequence(ev[8]), .i_memory_corrupt(ev[9]),
    .i_sequence_end(seq_end), .o_state(st), .o_stage_en(stage),
    .o_amplitude(amp), .o_play_start(), .o_play_repeat(),
    .o_play_abort(), .o_play_index(idx), .o_play_loops(loops),
    .o_play_multi(), .o_mem_access_ok(mem_ok),
    .o_event_line_low_o(irq_o), .o_event_line_low_oe(irq_oe));
  // --------
  // Bus and check helpers.
  // --------
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk("read data", exp, o_rdata);
  endtask
  // Waits are bounded so a stuck state is reported, not hung on.
  task automatic wait_st(hpm_state_t s);
    int n;
    n = 0;
    while (st !== s && n < 400) begin
      cyc(1);
      n++;
    end
    chk("state", 8'(s), 8'(st));
  endtask
  task automatic wait_amp(logic [7:0] exp);
    int n;
    n = 0;
    while (amp !== exp && n < 400) begin
      cyc(1);
      n++;
    end
    chk("amplitude", exp, amp);
  endtask
  task automatic end_seq();
    @(posedge i_clk);
    seq_end <= 1'b1;
    @(posedge i_clk);
    seq_end <= 1'b0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // --------
  // Scenarios.
  // --------
  task automatic t_boot();
    wr(ADDR_THR, 8'h55);
    wait_st(ST_IDLE);
    rd(ADDR_THR, THR_RESET);
    rd(ADDR_MASK1, MASK_RESET);
    rd(ADDR_CTRL, CTRL_RESET);
    rd(8'h77, 8'h00);
  endtask
  task automatic t_direct();
    wr(ADDR_AMP, 8'h40);
    wr(ADDR_MODE, 8'h01);
    wait_st(ST_WAKE);
    wait_st(ST_DRIVE);
    wait_amp(8'h40);
    cyc(2);
    chk("stage", 8'h01, 8'(stage));
    wr(ADDR_AMP, 8'h00);
    wait_amp(8'h00);
    cyc(2);
    chk("stage", 8'h00, 8'(stage));
    chk("state", 8'(ST_DRIVE), 8'(st));
    wr(ADDR_MODE, 8'h00);
    wait_st(ST_IDLE);
  endtask
  // Duty 2/8 gives 64; with overdrive 4/8 lands in the zero band.
  task automatic t_pwm();
    wr(ADDR_THR, 8'h10);
    pwm_en <= 1'b1;
    wr(ADDR_MODE, 8'h02);
    wait_st(ST_DRIVE);
    wait_amp(8'h40);
    wr(ADDR_CTRL, 8'h02);
    pwm_high <= 3'h4;
    wait_amp(8'h00);
    pwm_high <= 3'h6;
    wait_amp(8'h40);
    pwm_en <= 1'b0;
    wait_st(ST_IDLE);
    rd(ADDR_DIAG, 8'h04);
    rd(ADDR_FAULT, 8'h04);
    chk("event line", 8'h00, 8'(irq_n));
    wr(ADDR_MODE, 8'h00);
    pwm_en <= 1'b1;
    wr(ADDR_DIAG, 8'h04);
    wr(ADDR_FAULT, 8'h04);
    rd(ADDR_FAULT, 8'h00);
    cyc(3);
    chk("event line", 8'h01, 8'(irq_n));
  endtask
  task automatic t_memory();
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_SEQ, 8'h25);
    wr(ADDR_MODE, 8'h03);
    cyc(5);
    chk("held", 8'h00, 8'(st inside {ST_WAKE, ST_DRIVE}));
    wr(ADDR_TRIG, 8'h01);
    wait_st(ST_DRIVE);
    cyc(3);
    chk("index", 8'h05, 8'(idx));
    chk("loops", 8'h02, 8'(loops));
    wr(ADDR_TRIG, 8'h03);
    cyc(3);
    rd(ADDR_FAULT, 8'h40);
    end_seq();
    wait_st(ST_STANDBY);
    rd(ADDR_FAULT, 8'h60);
    cyc(2);
    chk("event line", 8'h00, 8'(irq_n));
    wr(ADDR_MASK1, 8'h60);
    cyc(3);
    chk("event line", 8'h01, 8'(irq_n));
    wr(ADDR_MASK1, 8'h00);
    wr(ADDR_FAULT, 8'h60);
    rd(ADDR_FAULT, 8'h00);
    wr(ADDR_TRIG, 8'h01);
    wait_st(ST_DRIVE);
    cyc(3);
    wr(ADDR_TRIG, 8'h00);
    wait_st(ST_STANDBY);
    wr(ADDR_TRIG, 8'h01);
    wait_st(ST_DRIVE);
    cyc(3);
    wr(ADDR_MODE, 8'h00);
    wait_st(ST_STANDBY);
  endtask
  task automatic t_edge();
    wr(ADDR_PIN0 + 8'h01, 8'h27);
    wr(ADDR_PIN0 + 8'h02, 8'h59);
    wr(ADDR_MODE, 8'h04);
    pins <= 3'b010;
    wait_st(ST_DRIVE);
    chk("index", 8'h07, 8'(idx));
    end_seq();
    wait_st(ST_STANDBY);
    pins <= 3'b110;
    cyc(8);
    chk("held", 8'h00, 8'(st inside {ST_WAKE, ST_DRIVE}));
    pins <= 3'b010;
    wait_st(ST_DRIVE);
    chk("index", 8'h09, 8'(idx));
    ev[0] <= 1'b1;
    cyc(1);
    ev[0] <= 1'b0;
    wait_st(ST_IDLE);
    pins <= 3'b000;
    cyc(6);
    pins <= 3'b010;
    cyc(8);
    chk("held", 8'h00, 8'(st inside {ST_WAKE, ST_DRIVE}));
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_FAULT, 8'hFF);
  endtask
  task automatic t_events();
    ev <= 10'h3FF;
    cyc(1);
    ev <= 10'h000;
    rd(ADDR_FAULT, 8'h9F);
    rd(ADDR_WARN, 8'h07);
    rd(ADDR_DIAG, 8'h03);
    wr(ADDR_WARN, 8'hFF);
    wr(ADDR_DIAG, 8'hFF);
    wr(ADDR_FAULT, 8'hFF);
    rd(ADDR_FAULT, 8'h00);
    rd(ADDR_DIAG, 8'h00);
    wr(ADDR_CTRL, 8'h04);
    cyc(3);
    chk("memory open", 8'h01, 8'(mem_ok));
    wr(ADDR_CTRL, 8'h00);
    cyc(3);
    chk("memory open", 8'h00, 8'(mem_ok));
  endtask
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    cyc(12);
    i_srst <= 1'b0;
    t_boot();
    t_direct();
    t_pwm();
    t_memory();
    t_edge();
    t_events();
    finish_test();
  end
endmodule
`default_nettype wire
